// File: logic/mpio_defs.svh
// register offsets, field masks and reset values for the multi-port pin bank
`ifndef MPIO_DEFS_SVH
`define MPIO_DEFS_SVH
`define MPIO_ADDR_W        12
`define MPIO_OFF_A_LATCH   12'h007
`define MPIO_OFF_B_LATCH   12'h008
`define MPIO_OFF_C_LATCH   12'h009
`define MPIO_OFF_A_PIN     12'h014
`define MPIO_OFF_B_PIN     12'h015
`define MPIO_OFF_C_PIN     12'h016
`define MPIO_OFF_A_DIR     12'hF21
`define MPIO_OFF_B_DIR     12'hF22
`define MPIO_OFF_C_DIR     12'hF23
`define MPIO_OFF_C_PULLUP  12'hF30
`define MPIO_OFF_A_FUNC    12'hF3B
`define MPIO_OFF_B_FUNC    12'hF3C
`define MPIO_OFF_C_FUNC    12'hF3D
`define MPIO_OFF_C_ODRAIN  12'hF4A
`define MPIO_RESET_VALUE   8'h00
`define MPIO_MASK_A_ALL    8'hFF
`define MPIO_MASK_A_FUNC   8'h1F
`define MPIO_MASK_B_ALL    8'h0F
`define MPIO_MASK_B_FUNC   8'h03
`define MPIO_MASK_C_ALL    8'h03
`endif

// File: logic/mpio_pkg.sv
// types shared by the multi-port pin bank
package mpio_pkg;
  // cpu side register access
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } mpio_bus_s;
  // one two-signal pin group of a port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mpio_drive_s;
endpackage

// File: logic/mpio_pin_slice.sv
// one pin: picks drive source, enable and read-back value
`timescale 1ns/1ps
module mpio_pin_slice (
  input  wire logic i_dir,
  input  wire logic i_func,
  input  wire logic i_latch,
  input  wire logic i_periph,
  input  wire logic i_odrain,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_enable,
  output logic      o_read
);
  // source select and open-drain handling
  always_comb begin
    o_level  = i_func ? i_periph : i_latch;
    // open drain drives only while the level is low
    o_enable = i_dir & ~(i_odrain & o_level);
    // input or open-drain output reads the pin, push-pull reads zero
    o_read   = (~i_dir | i_odrain) & i_pin;
  end
endmodule

// File: logic/mpio_bank.sv
// register file and pin muxing of the eight-, four- and two-pin ports
`timescale 1ns/1ps
`include "mpio_defs.svh"
module mpio_bank (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire mpio_pkg::mpio_bus_s i_bus,
  output logic [7:0]            o_rdata,
  input  wire logic [7:0]       i_pin_a,
  input  wire logic [3:0]       i_pin_b,
  input  wire logic [1:0]       i_pin_c,
  output mpio_pkg::mpio_drive_s o_drive_a,
  output logic [3:0]            o_out_b,
  output logic [3:0]            o_oe_b,
  output logic [1:0]            o_out_c,
  output logic [1:0]            o_oe_c,
  output logic [1:0]            o_pullup_c,
  input  wire logic             i_divider_out,
  input  wire logic [1:0]       i_alt_pulse_out,
  input  wire logic [3:0]       i_pulse_out,
  input  wire logic [3:0]       i_pwm_out,
  input  wire logic [3:0]       i_pwm_select,
  input  wire logic             i_serial_tx,
  output logic [2:0]            o_ext_irq_in,
  output logic [1:0]            o_alt_timer_in,
  output logic [3:0]            o_timer_in,
  output logic                  o_serial_rx
);
  import mpio_pkg::*;

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] a_latch, a_dir, a_func, b_latch, b_dir, b_func;
  logic [1:0] c_latch, c_dir, c_func, c_odrain, c_pullup;
  logic [7:0] next_a_latch, next_a_dir, next_a_func;
  logic [7:0] next_b_latch, next_b_dir, next_b_func;
  logic [1:0] next_c_latch, next_c_dir, next_c_func, next_c_odrain, next_c_pullup;
  logic [7:0] next_rdata;

  // byte writes, masked so read-only bits stay zero
  always_comb begin
    next_a_latch  = a_latch;
    next_a_dir    = a_dir;
    next_a_func   = a_func;
    next_b_latch  = b_latch;
    next_b_dir    = b_dir;
    next_b_func   = b_func;
    next_c_latch  = c_latch;
    next_c_dir    = c_dir;
    next_c_func   = c_func;
    next_c_odrain = c_odrain;
    next_c_pullup = c_pullup;
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `MPIO_OFF_A_LATCH:  next_a_latch = i_bus.wdata & `MPIO_MASK_A_ALL;
        `MPIO_OFF_A_DIR:    next_a_dir = i_bus.wdata & `MPIO_MASK_A_ALL;
        `MPIO_OFF_A_FUNC:   next_a_func = i_bus.wdata & `MPIO_MASK_A_FUNC;
        `MPIO_OFF_B_LATCH:  next_b_latch = i_bus.wdata & `MPIO_MASK_B_ALL;
        `MPIO_OFF_B_DIR:    next_b_dir = i_bus.wdata & `MPIO_MASK_B_ALL;
        `MPIO_OFF_B_FUNC:   next_b_func = i_bus.wdata & `MPIO_MASK_B_FUNC;
        `MPIO_OFF_C_LATCH:  next_c_latch = i_bus.wdata[1:0];
        `MPIO_OFF_C_DIR:    next_c_dir = i_bus.wdata[1:0];
        `MPIO_OFF_C_FUNC:   next_c_func = i_bus.wdata[1:0];
        `MPIO_OFF_C_ODRAIN: next_c_odrain = i_bus.wdata[1:0];
        `MPIO_OFF_C_PULLUP: next_c_pullup = i_bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // register bank; every field clears to zero while reset is low
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      a_latch  <= `MPIO_RESET_VALUE;
      a_dir    <= `MPIO_RESET_VALUE;
      a_func   <= `MPIO_RESET_VALUE;
      b_latch  <= `MPIO_RESET_VALUE;
      b_dir    <= `MPIO_RESET_VALUE;
      b_func   <= `MPIO_RESET_VALUE;
      c_latch  <= 2'h0;
      c_dir    <= 2'h0;
      c_func   <= 2'h0;
      c_odrain <= 2'h0;
      c_pullup <= 2'h0;
    end else begin
      a_latch  <= next_a_latch;
      a_dir    <= next_a_dir;
      a_func   <= next_a_func;
      b_latch  <= next_b_latch;
      b_dir    <= next_b_dir;
      b_func   <= next_b_func;
      c_latch  <= next_c_latch;
      c_dir    <= next_c_dir;
      c_func   <= next_c_func;
      c_odrain <= next_c_odrain;
      c_pullup <= next_c_pullup;
    end
  end

  // ************************************************************
  // pin slices
  // ************************************************************
  logic [7:0] a_per, a_lvl, a_en, a_rd;
  logic [3:0] b_per, b_lvl, b_en, b_rd;
  logic [1:0] c_lvl, c_en, c_rd;

  // peripheral output per pin; pwm select picks pwm over pulse
  always_comb begin
    a_per    = 8'h00;
    a_per[4] = i_divider_out;
    a_per[3] = i_alt_pulse_out[1];
    a_per[2] = i_alt_pulse_out[0];
    a_per[1] = i_pwm_select[1] ? i_pwm_out[1] : i_pulse_out[1];
    a_per[0] = i_pwm_select[0] ? i_pwm_out[0] : i_pulse_out[0];
    b_per    = 4'h0;
    b_per[1] = i_pwm_select[3] ? i_pwm_out[3] : i_pulse_out[3];
    b_per[0] = i_pwm_select[2] ? i_pwm_out[2] : i_pulse_out[2];
  end

  // one slice per pin; only port c has a real open-drain select
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_a
      mpio_pin_slice u_a (
        .i_dir(a_dir[g]), .i_func(a_func[g]), .i_latch(a_latch[g]),
        .i_periph(a_per[g]), .i_odrain(1'b0), .i_pin(i_pin_a[g]),
        .o_level(a_lvl[g]), .o_enable(a_en[g]), .o_read(a_rd[g])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : g_b
      mpio_pin_slice u_b (
        .i_dir(b_dir[g]), .i_func(b_func[g]), .i_latch(b_latch[g]),
        .i_periph(b_per[g]), .i_odrain(1'b0), .i_pin(i_pin_b[g]),
        .o_level(b_lvl[g]), .o_enable(b_en[g]), .o_read(b_rd[g])
      );
    end
    for (g = 0; g < 2; g = g + 1) begin : g_c
      mpio_pin_slice u_c (
        .i_dir(c_dir[g]), .i_func(c_func[g]), .i_latch(c_latch[g]),
        .i_periph(i_serial_tx), .i_odrain(c_odrain[g]), .i_pin(i_pin_c[g]),
        .o_level(c_lvl[g]), .o_enable(c_en[g]), .o_read(c_rd[g])
      );
    end
  endgenerate

  // ************************************************************
  // registered outputs
  // ************************************************************
  // read mux; idle cycles and unmapped offsets return zero
  always_comb begin
    next_rdata = 8'h00;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `MPIO_OFF_A_LATCH:  next_rdata = a_latch;
        `MPIO_OFF_A_DIR:    next_rdata = a_dir;
        `MPIO_OFF_A_FUNC:   next_rdata = a_func;
        `MPIO_OFF_A_PIN:    next_rdata = a_rd;
        `MPIO_OFF_B_LATCH:  next_rdata = b_latch;
        `MPIO_OFF_B_DIR:    next_rdata = b_dir;
        `MPIO_OFF_B_FUNC:   next_rdata = b_func;
        `MPIO_OFF_B_PIN:    next_rdata = {4'h0, b_rd};
        `MPIO_OFF_C_LATCH:  next_rdata = {6'h00, c_latch};
        `MPIO_OFF_C_DIR:    next_rdata = {6'h00, c_dir};
        `MPIO_OFF_C_FUNC:   next_rdata = {6'h00, c_func};
        `MPIO_OFF_C_ODRAIN: next_rdata = {6'h00, c_odrain};
        `MPIO_OFF_C_PULLUP: next_rdata = {6'h00, c_pullup};
        `MPIO_OFF_C_PIN:    next_rdata = {6'h00, c_rd};
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  logic [1:0] next_pullup_c;
  logic [2:0] next_ext_irq_in;
  logic [1:0] next_alt_timer_in;
  logic [3:0] next_timer_in;
  logic       next_serial_rx;

  // peripheral inputs see a pin only while it is an input; serial rx also sees port c pin 0 while it is an open-drain output
  always_comb begin
    next_pullup_c     = c_pullup & (~c_dir | c_odrain);
    next_ext_irq_in   = i_pin_a[7:5] & ~a_dir[7:5];
    next_alt_timer_in = i_pin_a[3:2] & ~a_dir[3:2];
    next_timer_in     = {i_pin_b[1:0] & ~b_dir[1:0], i_pin_a[1:0] & ~a_dir[1:0]};
    next_serial_rx    = c_rd[0];
  end

  // output flops; every top-level output leaves from here
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata        <= 8'h00;
      o_drive_a      <= '0;
      o_out_b        <= 4'h0;
      o_oe_b         <= 4'h0;
      o_out_c        <= 2'h0;
      o_oe_c         <= 2'h0;
      o_pullup_c     <= 2'h0;
      o_ext_irq_in   <= 3'h0;
      o_alt_timer_in <= 2'h0;
      o_timer_in     <= 4'h0;
      o_serial_rx    <= 1'b0;
    end else begin
      o_rdata        <= next_rdata;
      o_drive_a.out  <= a_lvl;
      o_drive_a.oe   <= a_en;
      o_out_b        <= b_lvl;
      o_oe_b         <= b_en;
      o_out_c        <= c_lvl;
      o_oe_c         <= c_en;
      o_pullup_c     <= next_pullup_c;
      o_ext_irq_in   <= next_ext_irq_in;
      o_alt_timer_in <= next_alt_timer_in;
      o_timer_in     <= next_timer_in;
      o_serial_rx    <= next_serial_rx;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // state and enables are clear on the first edge after reset
  dir_reset_a: assert property (@(posedge i_clock) $rose(i_resetn) |-> a_dir == 8'h00)
    else $error("direction not cleared at reset");
  reset_idle_a: assert property (@(posedge i_clock) $rose(i_resetn) |->
    (o_drive_a.oe == 8'h00 && o_oe_b == 4'h0 && o_oe_c == 2'h0))
    else $error("pin enabled at reset");
  latch_reset_a: assert property (@(posedge i_clock) $rose(i_resetn) |->
    (a_latch == 8'h00 && b_latch == 8'h00 && c_latch == 2'h0))
    else $error("latch not cleared at reset");
  func_reset_a: assert property (@(posedge i_clock) $rose(i_resetn) |->
    (a_func == 8'h00 && b_func == 8'h00 && c_func == 2'h0))
    else $error("function select not cleared at reset");
  // port a drive follows direction, latch and function select
  drive_latch_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (a_dir[5] && !a_func[5]) |=> o_drive_a.out[5] == $past(a_latch[5]))
    else $error("port a pin not driven by latch");
  func_route_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (a_dir[4] && a_func[4]) |=> o_drive_a.out[4] == $past(i_divider_out))
    else $error("divider not routed");
  oe_follow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    1 |=> o_drive_a.oe == $past(a_dir))
    else $error("port a enable not following direction");
  // port b: bits 3 and 2 stay plain io, bits 1 and 0 may carry a peripheral
  b_gpio_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    b_dir[3] |=> o_out_b[3] == $past(b_latch[3]) && o_oe_b[3])
    else $error("port b bit 3 not driven by latch");
  b_route_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (b_dir[0] && b_func[0] && i_pwm_select[2]) |=> o_out_b[0] == $past(i_pwm_out[2]))
    else $error("port b peripheral not routed");
  // interrupt and timer inputs are fed only from input-mode pins
  irq_feed_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    1 |=> o_ext_irq_in == ($past(i_pin_a[7:5]) & ~$past(a_dir[7:5])))
    else $error("irq input mismatch");
  alt_feed_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    1 |=> o_alt_timer_in == ($past(i_pin_a[3:2]) & ~$past(a_dir[3:2])))
    else $error("alternate timer input mismatch");
  timer_feed_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    1 |=> o_timer_in[3:2] == ($past(i_pin_b[1:0]) & ~$past(b_dir[1:0])))
    else $error("port b timer input mismatch");
  // pin reads return zero for push-pull outputs and unused bits
  pin_read_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_bus.rd && i_bus.addr == `MPIO_OFF_A_PIN) |=> o_rdata == ($past(i_pin_a) & ~$past(a_dir)))
    else $error("port a pin read wrong");
  b_upper_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    b_dir[7:4] == 4'h0 && b_func[7:2] == 6'h00)
    else $error("port b read-only bits set");
  b_read_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_bus.rd && i_bus.addr == `MPIO_OFF_B_PIN) |=> o_rdata[7:4] == 4'h0)
    else $error("port b upper read nonzero");
  c_read_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_bus.rd && i_bus.addr == `MPIO_OFF_C_PIN) |=>
    o_rdata == {6'h00, $past(i_pin_c) & (~$past(c_dir) | $past(c_odrain))})
    else $error("port c pin read wrong");
  // port c output stage, serial routing and pull-up gating
  odrain_hi_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (c_dir[0] && c_odrain[0] && c_lvl[0]) |=> !o_oe_c[0])
    else $error("open drain drove high");
  serial_route_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (c_dir[1] && c_func[1] && !c_odrain[1]) |=> o_out_c[1] == $past(i_serial_tx) && o_oe_c[1])
    else $error("serial transmit not routed");
  pullup_gate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (c_dir[1] && !c_odrain[1]) |=> !o_pullup_c[1])
    else $error("pull-up on push-pull pin");
  pullup_on_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (c_pullup[0] && !c_dir[0]) |=> o_pullup_c[0])
    else $error("pull-up missing on input pin");
endmodule

// File: tb/mpio_board.sv
// board model: resolves every port pin from device drive and board levels
`timescale 1ns/1ps
module mpio_board (
  input  wire mpio_pkg::mpio_drive_s i_drive_a,
  input  wire logic [3:0]            i_out_b,
  input  wire logic [3:0]            i_oe_b,
  input  wire logic [1:0]            i_out_c,
  input  wire logic [1:0]            i_oe_c,
  input  wire logic [1:0]            i_pullup_c,
  input  wire logic [7:0]            i_ext_a,
  input  wire logic [3:0]            i_ext_b,
  input  wire logic [1:0]            i_ext_c,
  input  wire logic [1:0]            i_float_c,
  output logic [7:0]                 o_pin_a,
  output logic [3:0]                 o_pin_b,
  output logic [1:0]                 o_pin_c
);
  import mpio_pkg::*;
  logic [1:0] pulled;
  // a driven pin shows the device level, a released one the board level
  assign o_pin_a = (i_drive_a.oe & i_drive_a.out) | (~i_drive_a.oe & i_ext_a);
  assign o_pin_b = (i_oe_b & i_out_b) | (~i_oe_b & i_ext_b);
  // a released port c line reads high if it floats with the pull-up connected, otherwise it shows the board level
  assign pulled  = i_float_c & i_pullup_c;
  assign o_pin_c = (i_oe_c & i_out_c) | (~i_oe_c & (pulled | (~pulled & i_ext_c)));
endmodule

// File: tb/tb.sv
// self-checking bench for the multi-port pin bank
`timescale 1ns/1ps
`include "mpio_defs.svh"
module tb;
  import mpio_pkg::*;
  // ****************************************
  // signals, register table and helpers
  // ****************************************
  logic clock = 1'b0, resetn = 1'b0, div, tx, serial_rx;
  mpio_bus_s bus;
  mpio_drive_s drive_a;
  logic [7:0] rdata, pin_a, ext_a, pa, d, v[11], ra;
  logic [3:0] pin_b, ext_b, out_b, oe_b, pls, pwm, sel, pb, timer_in;
  logic [1:0] pin_c, ext_c, flt, out_c, oe_c, pu_c, alt, pc, alt_in, lc, dc, od;
  logic [2:0] irq_in;
  logic [11:0] ad[11] = '{`MPIO_OFF_A_LATCH, `MPIO_OFF_A_DIR, `MPIO_OFF_A_FUNC,
    `MPIO_OFF_B_LATCH, `MPIO_OFF_B_DIR, `MPIO_OFF_B_FUNC, `MPIO_OFF_C_LATCH,
    `MPIO_OFF_C_DIR, `MPIO_OFF_C_PULLUP, `MPIO_OFF_C_FUNC, `MPIO_OFF_C_ODRAIN};
  logic [7:0] mk[11] = '{8'hFF, 8'hFF, 8'h1F, 8'h0F, 8'h0F, 8'h03, 8'h03, 8'h03, 8'h03,
    8'h03, 8'h03};
  int error_cnt = 0, samples_checked = 0, seed = 92, it, i;
  always #25 clock = ~clock;
  mpio_bank i_mpio_bank (.i_clock(clock), .i_resetn(resetn), .i_bus(bus), .o_rdata(rdata),
    .i_pin_a(pin_a), .i_pin_b(pin_b), .i_pin_c(pin_c), .o_drive_a(drive_a), .o_out_b(out_b),
    .o_oe_b(oe_b), .o_out_c(out_c), .o_oe_c(oe_c), .o_pullup_c(pu_c), .i_divider_out(div),
    .i_alt_pulse_out(alt), .i_pulse_out(pls), .i_pwm_out(pwm), .i_pwm_select(sel),
    .i_serial_tx(tx), .o_ext_irq_in(irq_in), .o_alt_timer_in(alt_in),
    .o_timer_in(timer_in), .o_serial_rx(serial_rx));
  mpio_board i_mpio_board (.i_drive_a(drive_a), .i_out_b(out_b), .i_oe_b(oe_b),
    .i_out_c(out_c), .i_oe_c(oe_c), .i_pullup_c(pu_c), .i_ext_a(ext_a), .i_ext_b(ext_b),
    .i_ext_c(ext_c), .i_float_c(flt), .o_pin_a(pin_a), .o_pin_b(pin_b), .o_pin_c(pin_c));
  // compare one value and count it
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one write strobe, then one idle cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    bus <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
  endtask
  // one read strobe; pins captured at the sampling edge, data taken while it stands
  task automatic rd(input logic [11:0] a, output logic [7:0] x);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    pa = pin_a;
    pb = pin_b;
    pc = pin_c;
    bus.rd <= 1'b0;
    #1 x = rdata;
    @(posedge clock);
  endtask
  // every register and every enable is clear after reset
  task automatic reset_check();
    for (i = 0; i < 11; i++) begin
      rd(ad[i], d);
      chk("reset reg", d, 8'h00);
    end
    chk("reset oe", drive_a.oe | {4'h0, oe_b} | {6'h00, oe_c}, 8'h00);
  endtask
  // expected drive of port a from latch, direction and function bits
  function automatic logic [7:0] exp_a(logic [7:0] l, logic [7:0] dr, logic [7:0] f);
    logic [7:0] p;
    p = {3'b000, div, alt, sel[1] ? pwm[1] : pls[1], sel[0] ? pwm[0] : pls[0]};
    return dr & ((f & p) | (~f & l));
  endfunction
  task automatic report_and_stop();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    bus = '0;
    {ext_a, ext_b, ext_c, flt, div, tx, alt, pls, pwm, sel} = '0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    reset_check();
    wr(12'hF99, 8'hFF);
    rd(12'hF99, d);
    chk("unmapped", d, 8'h00);
    for (it = 0; it < 40; it++) begin
      for (i = 0; i < 11; i++) v[i] = (it == 0) ? 8'hFF : 8'($random(seed));
      {ext_a, ext_b, ext_c, flt, div, tx, alt, pls, pwm, sel} <= 32'($random(seed));
      for (i = 0; i < 11; i++) wr(ad[i], v[i]);
      for (i = 0; i < 11; i++) begin
        rd(ad[i], d);
        chk("reg", d, v[i] & mk[i]);
      end
      ra = v[1];
      {lc, dc, od} = {v[6][1:0], v[7][1:0], v[10][1:0]};
      rd(`MPIO_OFF_A_PIN, d);
      chk("pin a", d, pa & ~ra);
      rd(`MPIO_OFF_B_PIN, d);
      chk("pin b", d, {4'h0, pb & ~v[4][3:0]});
      rd(`MPIO_OFF_C_PIN, d);
      chk("pin c", d, {6'h00, pc & (~dc | od)});
      chk("oe a", drive_a.oe, ra);
      chk("out a", drive_a.out & ra, exp_a(v[0], ra, v[2] & 8'h1F));
      chk("oe b", {4'h0, oe_b}, v[4] & 8'h0F);
      chk("out b", {4'h0, out_b & v[4][3:0]}, {4'h0, v[4][3:0] & ((v[5][3:0] & 4'h3 & {2'b00,
        sel[3] ? pwm[3] : pls[3], sel[2] ? pwm[2] : pls[2]}) | (~(v[5][3:0] & 4'h3) &
        v[3][3:0]))});
      chk("pullup", {6'h00, pu_c}, {6'h00, v[8][1:0] & (~dc | od)});
      chk("oe c", {6'h00, oe_c & ~od}, {6'h00, dc & ~od});
      chk("out c", {6'h00, out_c & dc & ~od}, {6'h00, dc & ~od & ((v[9][1:0] & {2{tx}}) |
        (~v[9][1:0] & lc))});
      chk("od high", {6'h00, out_c & oe_c & od}, 8'h00);
      // the serial selection lives outside this block; only the pin side is checked
      chk("serial rx", {7'h00, serial_rx}, {7'h00, pin_c[0] & (~dc[0] | od[0])});
      chk("irq in", {5'h00, irq_in}, {5'h00, pin_a[7:5] & ~ra[7:5]});
      chk("alt in", {6'h00, alt_in & ~ra[3:2]}, {6'h00, pin_a[3:2] & ~ra[3:2]});
      chk("timer in", {4'h0, timer_in}, {4'h0, {pin_b[1:0], pin_a[1:0]} &
        ~{v[4][1:0], ra[1:0]}});
    end
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    reset_check();
    report_and_stop();
  end
endmodule
